// ==== src/adaptation_pkg.sv ====
/*
  Constants, register map and carrier types for the path to TUG-2
  adaptation sink. Assumes a 10 MHz core clock and an AHB-Lite master.
*/
// How it works
// - Enables for 20, 60, 60 tributary sinks.
// - Only implemented sinks can be enabled.
// - Several sinks may share one timeslot.
// - Accepted label compared against fixed 011.
// - Label differs from expected: mismatch defect.
// - Recover multiframe phase from bits 6-7.
// - One sequence error drops alignment at once.
// - Four error-free frames regain alignment.
// - Lost alignment for 3 ms: loss defect.
// - Loss defect clears on regaining alignment.
// - Disabled: assert server fail, hide status except overrun.
// - Server fail from either defect.
// - Mismatch fault only without incoming fail.
// - Loss fault needs no fail, no mismatch.
package adaptation_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] STATUS_OFF  = 8'h04;
  localparam logic [7:0] S2_EN_OFF   = 8'h08;
  localparam logic [7:0] S12_LO_OFF  = 8'h0C;
  localparam logic [7:0] S12_HI_OFF  = 8'h10;
  localparam logic [7:0] S11_LO_OFF  = 8'h14;
  localparam logic [7:0] S11_HI_OFF  = 8'h18;
  localparam logic       ENABLE_RST  = 1'h0;

  // ==========================================================
  // Status field positions
  localparam int ST_PLM      = 0;
  localparam int ST_LOM      = 1;
  localparam int ST_HELD     = 2;
  localparam int ST_PLM_F    = 3;
  localparam int ST_LOM_F    = 4;
  localparam int ST_SSF      = 5;
  localparam int ST_OVERRUN  = 6;
  localparam int ST_LABEL    = 8;

  // ==========================================================
  // Overhead processing
  localparam logic [2:0] EXPECTED_LABEL = 3'h3;
  localparam logic [2:0] LABEL_ACCEPT_N = 3'h5;
  localparam logic [2:0] ALIGN_FRAMES   = 3'h4;
  localparam logic [1:0] MF_LAST_CODE   = 2'h2;
  localparam logic [7:0] MA_POS_DEF     = 8'h03;

  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 10000000;
  localparam int LOM_TIME_MS = 3;
  localparam int LOM_CYCLES  = (LOM_TIME_MS * CLK_HZ) / 1000;

  // ==========================================================
  // Tributary sink counts
  localparam int S2_N  = 20;
  localparam int S12_N = 60;
  localparam int S11_N = 60;

  typedef enum logic
  {
    ALIGNMENT_LOST_STATE = 1'b0,
    ALIGNMENT_HELD_STATE = 1'b1
  } align_state_t;

  typedef struct packed
  {
    logic [S11_N-1:0] s11;
    logic [S12_N-1:0] s12;
    logic [S2_N-1:0]  s2;
  } trib_enable_t;

  typedef struct packed
  {
    logic       multiframe_start_out;
    logic       frame_start;
    logic [7:0] data;
  } tug2_word_t;

endpackage

// ==== src/path_to_tug2_adaptation_sink.sv ====
/*
  Path to TUG-2 adaptation sink with its AHB-Lite register slave and
  output FIFO. Assumes the path stream arrives byte-wide with its own
  clock and frame start, and a single AHB-Lite master for management.
*/
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Stream FIFO
module stream_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
)
(
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule

// ============================================================
// Adaptation sink top
module path_to_tug2_adaptation_sink
#(
  parameter int          LOM_CYCLES = adaptation_pkg::LOM_CYCLES,
  parameter logic [7:0]  MA_POS     = adaptation_pkg::MA_POS_DEF,
  parameter int          FIFO_DEPTH = 32,
  parameter logic [19:0] S2_IMPL    = 20'hF_FFFF,
  parameter logic [59:0] S12_IMPL   = 60'hFFF_FFFF_FFFF_FFFF,
  parameter logic [59:0] S11_IMPL   = 60'hFFF_FFFF_FFFF_FFFF
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  input  wire logic                        p4s_clk,
  input  wire logic [7:0]                  p4s_data,
  input  wire logic                        p4s_fs,
  input  wire logic                        incoming_trail_fail,
  output logic                             tug2_clk,
  output logic                             tug2_valid,
  input  wire logic                        tug2_ready,
  output adaptation_pkg::tug2_word_t       tug2_word,
  output logic                             server_signal_fail_flag,
  output logic                             trail_fail_action,
  output logic                             label_mismatch_fault,
  output logic                             multiframe_loss_fault,
  output adaptation_pkg::trib_enable_t     trib_enable
);
  localparam int LW = $clog2(LOM_CYCLES + 1);

  logic [9:0]  s1_reg;
  logic [9:0]  s2_reg;
  logic [9:0]  s3_reg;
  logic [9:0]  lvl_reg;
  logic [9:0]  agree;
  logic        rise;
  logic [7:0]  byte_in;
  logic        fs_in;
  logic [7:0]  pos_reg;
  logic        in_frame_reg;
  logic        ma_hit;
  logic [2:0]  label_in;
  logic [1:0]  code_in;
  logic        seq_ok;
  logic [2:0]  cand_reg;
  logic [2:0]  cand_cnt_reg;
  logic [2:0]  accepted_reg;
  logic        label_mismatch_defect_reg;
  adaptation_pkg::align_state_t state_reg;
  logic [1:0]  prev_code_reg;
  logic [2:0]  good_reg;
  logic [LW-1:0] lom_cnt_reg;
  logic        multiframe_loss_defect_reg;
  logic        enable_reg;
  logic        overrun_reg;
  adaptation_pkg::trib_enable_t trib_reg;
  logic        push_ready;
  logic        push_valid;
  adaptation_pkg::tug2_word_t push_word;
  logic        ssf_reg;
  logic        plm_f_reg;
  logic        lom_f_reg;
  logic        access;
  logic        wr_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_next;
  logic [31:0] status_word;
  logic        clr_overrun;

  // ==========================================================
  // Link input sampling
  assign agree   = ~(s2_reg ^ s3_reg);
  assign rise    = agree[0] & s3_reg[0] & ~lvl_reg[0];
  assign byte_in = s3_reg[9:2];
  assign fs_in   = s3_reg[1];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg  <= {p4s_data, p4s_fs, p4s_clk};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= (lvl_reg & ~agree) | (s3_reg & agree);
    end
  end

  // ==========================================================
  // Frame position and overhead byte
  assign ma_hit   = rise & in_frame_reg & ~fs_in & (pos_reg == MA_POS);
  assign label_in = byte_in[5:3];
  assign code_in  = byte_in[2:1];
  assign seq_ok   = code_in == 2'(prev_code_reg + 2'h1);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pos_reg      <= '0;
      in_frame_reg <= 1'b0;
    end
    else if (rise)
    begin
      if (fs_in)
      begin
        pos_reg      <= 8'h01;
        in_frame_reg <= 1'b1;
      end
      else if (pos_reg != 8'hFF)
      begin
        pos_reg <= pos_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // Label acceptance and mismatch
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cand_reg     <= adaptation_pkg::EXPECTED_LABEL;
      cand_cnt_reg <= '0;
      accepted_reg <= adaptation_pkg::EXPECTED_LABEL;
    end
    else if (ma_hit)
    begin
      cand_reg <= label_in;
      if (label_in != cand_reg)
      begin
        cand_cnt_reg <= 3'h1;
      end
      else if (cand_cnt_reg != adaptation_pkg::LABEL_ACCEPT_N)
      begin
        cand_cnt_reg <= cand_cnt_reg + 3'h1;
        if (cand_cnt_reg == adaptation_pkg::LABEL_ACCEPT_N - 3'h1)
        begin
          accepted_reg <= label_in;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      label_mismatch_defect_reg <= 1'b0;
    end
    else
    begin
      label_mismatch_defect_reg <= accepted_reg != adaptation_pkg::EXPECTED_LABEL;
    end
  end

  // ==========================================================
  // Multiframe alignment
  // phase from bits six, seven.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg     <= adaptation_pkg::ALIGNMENT_LOST_STATE;
      prev_code_reg <= '0;
      good_reg      <= '0;
    end
    else if (ma_hit)
    begin
      prev_code_reg <= code_in;
      case (state_reg)
        adaptation_pkg::ALIGNMENT_LOST_STATE:
        begin
          if (!seq_ok)
          begin
            good_reg <= '0;
          end
          else if (good_reg == adaptation_pkg::ALIGN_FRAMES - 3'h1)
          begin
            good_reg  <= '0;
            state_reg <= adaptation_pkg::ALIGNMENT_HELD_STATE;
          end
          else
          begin
            good_reg <= good_reg + 3'h1;
          end
        end
        default:
        begin
          if (!seq_ok)
          begin
            state_reg <= adaptation_pkg::ALIGNMENT_LOST_STATE;
          end
        end
      endcase
    end
  end

  // Counting from reset means a dead link also ends in loss defect.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lom_cnt_reg <= '0;
      multiframe_loss_defect_reg    <= 1'b0;
    end
    else if (state_reg == adaptation_pkg::ALIGNMENT_HELD_STATE)
    begin
      lom_cnt_reg <= '0;
      multiframe_loss_defect_reg    <= 1'b0;
    end
    else if (lom_cnt_reg == LW'(LOM_CYCLES - 1))
    begin
      multiframe_loss_defect_reg <= 1'b1;
    end
    else
    begin
      lom_cnt_reg <= lom_cnt_reg + LW'(1);
    end
  end

  // ==========================================================
  // Consequent actions and fault causes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ssf_reg   <= 1'b1;
      plm_f_reg <= 1'b0;
      lom_f_reg <= 1'b0;
    end
    else
    begin
      ssf_reg   <= ~enable_reg | label_mismatch_defect_reg | multiframe_loss_defect_reg;
      plm_f_reg <= enable_reg & label_mismatch_defect_reg & ~incoming_trail_fail;
      lom_f_reg <= enable_reg & multiframe_loss_defect_reg & ~incoming_trail_fail
                   & ~label_mismatch_defect_reg;
    end
  end

  assign server_signal_fail_flag = ssf_reg;
  assign trail_fail_action       = ssf_reg;
  assign label_mismatch_fault    = plm_f_reg;
  assign multiframe_loss_fault   = lom_f_reg;

  // ==========================================================
  // Stream toward the tributary stage
  // bytes pass unchanged.
  assign push_valid          = rise & in_frame_reg | rise & fs_in;
  assign push_word.data        = byte_in;
  assign push_word.frame_start = fs_in;
  assign push_word.multiframe_start_out =
    fs_in & (state_reg == adaptation_pkg::ALIGNMENT_HELD_STATE)
    & (prev_code_reg == adaptation_pkg::MF_LAST_CODE);
  assign tug2_clk = lvl_reg[0];

  // The link cannot be stalled, so a full FIFO drops the byte.
  stream_fifo
  #(
    .WIDTH ($bits(adaptation_pkg::tug2_word_t)),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (tug2_valid),
    .out_ready (tug2_ready),
    .out_data  (tug2_word)
  );

  // ==========================================================
  // AHB-Lite register slave
  assign access      = hsel & htrans[1] & hready;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_reg;
  assign trib_enable = trib_reg;
  assign clr_overrun = wr_pend_reg & (addr_reg == adaptation_pkg::STATUS_OFF)
                       & hwdata[adaptation_pkg::ST_OVERRUN];

  always_comb
  begin
    status_word = '0;
    if (enable_reg)
    begin
      status_word[adaptation_pkg::ST_PLM]   = label_mismatch_defect_reg;
      status_word[adaptation_pkg::ST_LOM]   = multiframe_loss_defect_reg;
      status_word[adaptation_pkg::ST_HELD]  = state_reg;
      status_word[adaptation_pkg::ST_PLM_F] = plm_f_reg;
      status_word[adaptation_pkg::ST_LOM_F] = lom_f_reg;
      status_word[adaptation_pkg::ST_SSF]   = ssf_reg;
      status_word[adaptation_pkg::ST_LABEL +: 3] = accepted_reg;
    end
    status_word[adaptation_pkg::ST_OVERRUN] = overrun_reg;
  end

  always_comb
  begin
    rd_next = '0;
    if (haddr[7:0] == adaptation_pkg::CTRL_OFF)
    begin
      rd_next[0] = enable_reg;
    end
    else if (haddr[7:0] == adaptation_pkg::STATUS_OFF)
    begin
      rd_next = status_word;
    end
    else if (haddr[7:0] == adaptation_pkg::S2_EN_OFF)
    begin
      rd_next[19:0] = trib_reg.s2;
    end
    else if (haddr[7:0] == adaptation_pkg::S12_LO_OFF)
    begin
      rd_next = trib_reg.s12[31:0];
    end
    else if (haddr[7:0] == adaptation_pkg::S12_HI_OFF)
    begin
      rd_next[27:0] = trib_reg.s12[59:32];
    end
    else if (haddr[7:0] == adaptation_pkg::S11_LO_OFF)
    begin
      rd_next = trib_reg.s11[31:0];
    end
    else if (haddr[7:0] == adaptation_pkg::S11_HI_OFF)
    begin
      rd_next[27:0] = trib_reg.s11[59:32];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
      hrdata_reg  <= '0;
    end
    else
    begin
      wr_pend_reg <= access & hwrite;
      addr_reg    <= haddr[7:0];
      if (access & ~hwrite)
      begin
        hrdata_reg <= rd_next;
      end
    end
  end

  // Overrun is sticky; a new drop wins over a clear in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      overrun_reg <= 1'b0;
    end
    else
    begin
      overrun_reg <= (overrun_reg & ~clr_overrun) | (push_valid & ~push_ready);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      enable_reg <= adaptation_pkg::ENABLE_RST;
      trib_reg   <= '0;
    end
    else if (wr_pend_reg)
    begin
      if (addr_reg == adaptation_pkg::CTRL_OFF)
      begin
        enable_reg <= hwdata[0];
      end
      else if (addr_reg == adaptation_pkg::S2_EN_OFF)
      begin
        trib_reg.s2 <= hwdata[19:0] & S2_IMPL;
      end
      else if (addr_reg == adaptation_pkg::S12_LO_OFF)
      begin
        trib_reg.s12[31:0] <= hwdata & S12_IMPL[31:0];
      end
      else if (addr_reg == adaptation_pkg::S12_HI_OFF)
      begin
        trib_reg.s12[59:32] <= hwdata[27:0] & S12_IMPL[59:32];
      end
      else if (addr_reg == adaptation_pkg::S11_LO_OFF)
      begin
        trib_reg.s11[31:0] <= hwdata & S11_IMPL[31:0];
      end
      else if (addr_reg == adaptation_pkg::S11_HI_OFF)
      begin
        trib_reg.s11[59:32] <= hwdata[27:0] & S11_IMPL[59:32];
      end
    end
  end
endmodule

`default_nettype wire

// ==== bench/sink_asserts.sv ====
/*
  Port checker for the adaptation sink top module.
  Assumes it is bound to that top module and shares its reset.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module sink_asserts
#(
  parameter int LOM_CYCLES = 200
)
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        p4s_clk,
  input wire logic        incoming_trail_fail,
  input wire logic        tug2_clk,
  input wire logic        tug2_valid,
  input wire logic        tug2_ready,
  input wire logic [9:0]  tug2_word,
  input wire logic        server_signal_fail_flag,
  input wire logic        trail_fail_action,
  input wire logic        label_mismatch_fault,
  input wire logic        multiframe_loss_fault
);
  int since_rst;
  // Saturating, so the count costs nothing on long runs.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      since_rst <= 0;
    else if (since_rst < LOM_CYCLES)
      since_rst <= since_rst + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence read_addr;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence stalled;
    tug2_valid && !tug2_ready;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_rdata_holds: assert property
    (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_word_holds: assert property
    (stalled |=> tug2_valid && $stable(tug2_word))
    else $error("stream word changed while stalled");
  a_clk_passes: assert property
    ((tug2_clk != $past(tug2_clk)) |-> (tug2_clk == $past(p4s_clk, 2)))
    else $error("tributary clock does not follow link clock");
  a_trail_follows: assert property
    (trail_fail_action == server_signal_fail_flag)
    else $error("trail fail differs from server fail");
  a_label_fault_itf: assert property
    (label_mismatch_fault |-> !$past(incoming_trail_fail))
    else $error("label fault during incoming fail");
  a_loss_fault_itf: assert property
    (multiframe_loss_fault |-> !$past(incoming_trail_fail))
    else $error("loss fault during incoming fail");
  a_faults_exclusive: assert property
    (!(label_mismatch_fault && multiframe_loss_fault))
    else $error("loss fault beside label fault");
  a_mfs_on_fs: assert property
    (tug2_valid && tug2_word[9] |-> tug2_word[8])
    else $error("multiframe start off the frame start");
  a_loss_not_early: assert property
    (multiframe_loss_fault |-> since_rst >= LOM_CYCLES - 1)
    else $error("loss fault before the loss time");
  c_read: cover property (read_addr);
endmodule

bind path_to_tug2_adaptation_sink sink_asserts
  #(.LOM_CYCLES(LOM_CYCLES)) u_sink_asserts
(
  .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .p4s_clk(p4s_clk),
  .incoming_trail_fail(incoming_trail_fail), .tug2_clk(tug2_clk),
  .tug2_valid(tug2_valid), .tug2_ready(tug2_ready),
  .tug2_word(tug2_word), .trail_fail_action(trail_fail_action),
  .server_signal_fail_flag(server_signal_fail_flag),
  .label_mismatch_fault(label_mismatch_fault),
  .multiframe_loss_fault(multiframe_loss_fault)
);
`default_nettype wire

// ==== bench/link_source.sv ====
/*
  Path stream source: eight-byte frames, one byte per link clock.
  Assumes the link clock is eight core cycles long.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Link source
module link_source
(
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [2:0] label,
  input  wire logic       err,
  output logic            p4s_clk,
  output logic [7:0]      p4s_data,
  output logic            p4s_fs,
  output logic [7:0]      frame_no
);
  logic [2:0] ph = 3'h7;
  logic [2:0] idx = 3'h0;
  logic [2:0] lab_l = 3'h3;
  logic       err_l = 1'b0;
  logic [1:0] code;
  initial
  begin
    p4s_clk = 1'b0;
    p4s_data = 8'h00;
    p4s_fs = 1'b0;
    frame_no = 8'h00;
  end
  // A fault adds two, which no alignment can take for the next code.
  assign code = frame_no[1:0] + 2'h3 + {err_l, 1'b0};
  // Data change while the clock is low, so they are stable at its rise.
  always @(posedge ref_clk)
  begin
    if (!run)
    begin
      p4s_clk <= 1'b0;
      p4s_data <= ~p4s_data;
      p4s_fs <= ~p4s_fs;
      ph <= 3'h7;
    end
    else
    begin
      ph <= ph + 3'h1;
      p4s_clk <= (ph >= 3'h3) && (ph != 3'h7);
      if (ph == 3'h7)
      begin
        p4s_data <= (idx == 3'h3) ? {2'h0, lab_l, code, 1'b0}
                                  : {frame_no[4:0], idx};
        p4s_fs <= (idx == 3'h0);
        idx <= idx + 3'h1;
        if (idx == 3'h7)
        begin
          frame_no <= frame_no + 8'h01;
          lab_l <= label;
          err_l <= err;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
  Self-checking bench for the adaptation sink.
  Assumes the link source model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench
module tb;
  localparam int LOMC = 100;
  localparam logic [7:0] STA = adaptation_pkg::STATUS_OFF;
  localparam logic [7:0] OFF [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  localparam logic [31:0] MSK [5] = '{32'h000F_FFFF, 32'hFFFF_FFFF,
    32'h0FFF_FFFF, 32'hFFFF_FFFF, 32'h0FFF_FFFF};
  logic         ref_clk = 1'b0;
  logic         srst = 1'b1;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0000_0000;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0000_0000;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         p4s_clk;
  logic [7:0]   p4s_data;
  logic         p4s_fs;
  logic [7:0]   frame_no;
  logic         itf = 1'b0;
  logic         tug2_valid;
  logic         tug2_ready = 1'b0;
  logic [9:0]   tug2_word;
  logic         sf;
  logic         lf;
  logic         mlf;
  logic [139:0] te;
  logic         run = 1'b0;
  logic [2:0]   label = 3'h3;
  logic         err = 1'b0;
  logic         chk_on = 1'b1;
  logic         drain = 1'b0;
  logic [31:0]  rng_bus = 32'h0000_1CCE;
  logic [31:0]  rng_pop = 32'h0000_1CCE;
  logic [31:0]  q;
  logic [31:0]  v [5];
  int           n_fail = 0;
  int           n_tests = 0;
  int           f_e = 0;
  int           i_e = 0;
  int           n_pop = 0;
  int           n_mfs = 0;
  int           np0;
  int           k;

  always #50 ref_clk = ~ref_clk;

  path_to_tug2_adaptation_sink #(.LOM_CYCLES(LOMC)) u_path_to_tug2_adaptation_sink
  (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .p4s_clk(p4s_clk), .p4s_data(p4s_data),
    .p4s_fs(p4s_fs), .incoming_trail_fail(itf), .tug2_clk(),
    .tug2_valid(tug2_valid), .tug2_ready(tug2_ready),
    .tug2_word(tug2_word), .server_signal_fail_flag(sf),
    .trail_fail_action(), .label_mismatch_fault(lf),
    .multiframe_loss_fault(mlf), .trib_enable(te)
  );

  link_source u_link_source
  (
    .ref_clk(ref_clk), .run(run), .label(label), .err(err),
    .p4s_clk(p4s_clk), .p4s_data(p4s_data), .p4s_fs(p4s_fs),
    .frame_no(frame_no)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Bits are overrun, fail, loss, label fault, held, loss, mismatch.
  function automatic logic [31:0] st(input logic [6:0] b,
                                     input logic [2:0] lab);
    return {21'h0, lab, 1'b0, b};
  endfunction

  task give_verdict;
    $display("counts: %0d compared, %0d wrong", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [139:0] got, input logic [139:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task timeout;
    n_fail++;
    give_verdict;
  endtask

  task wait_rdy;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
      timeout;
  endtask

  // The idle cycle first keeps a read from landing beside a write.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  task frames(input int n);
    logic [7:0] fn;
    repeat (n)
    begin
      fn = frame_no;
      k = 0;
      while (frame_no === fn && k < 200)
      begin
        @(negedge ref_clk);
        k++;
      end
      if (k >= 200)
        timeout;
    end
    @(posedge ref_clk);
  endtask

  task end_test(input string s);
    $display("test %0s finished", s);
  endtask

  // Pops follow the sent stream; the type byte is left to the status.
  always @(posedge ref_clk)
  begin
    if (!srst && tug2_valid === 1'b1 && tug2_ready === 1'b1)
    begin
      n_pop++;
      if (chk_on)
      begin
        if (i_e != 3)
          check(tug2_word[7:0], {f_e[4:0], i_e[2:0]});
        check(tug2_word[8], i_e == 0);
        if (tug2_word[9] === 1'b1)
        begin
          n_mfs++;
          check(f_e[1:0], 2'h0);
        end
        i_e = (i_e + 1) % 8;
        if (i_e == 0)
          f_e++;
      end
    end
    rng_pop = xs(rng_pop);
    tug2_ready <= drain | (chk_on & rng_pop[0]);
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(adaptation_pkg::CTRL_OFF, 32'h0000_0000);
    rd_chk(STA, 32'h0000_0000);
    rd_chk(8'h1C, 32'h0000_0000);
    check(sf, 1'b1);
    check(te, 140'h0);
    end_test("defaults");
    for (int p = 0; p < 2; p++)
    begin
      for (int r = 0; r < 5; r++)
      begin
        rng_bus = xs(rng_bus);
        v[r] = (p == 0) ? 32'hFFFF_FFFF : rng_bus;
        bus(1'b1, OFF[r], v[r]);
        v[r] = v[r] & MSK[r];
      end
      for (int r = 0; r < 5; r++)
        rd_chk(OFF[r], v[r]);
      check(te, {v[4][27:0], v[3], v[2][27:0], v[1], v[0][19:0]});
    end
    end_test("enables");
    run <= 1'b1;
    bus(1'b1, adaptation_pkg::CTRL_OFF, 32'h0000_0001);
    frames(12);
    rd_chk(STA, st(7'h04, 3'h3));
    check(sf, 1'b0);
    check(n_mfs > 0, 1'b1);
    end_test("aligned");
    err <= 1'b1;
    frames(1);
    err <= 1'b0;
    repeat (48) @(posedge ref_clk);
    rd_chk(STA, st(7'h00, 3'h3));
    repeat (110) @(posedge ref_clk);
    rd_chk(STA, st(7'h32, 3'h3));
    check(mlf, 1'b1);
    itf <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(mlf, 1'b0);
    check(sf, 1'b1);
    itf <= 1'b0;
    frames(6);
    rd_chk(STA, st(7'h04, 3'h3));
    check(mlf, 1'b0);
    end_test("loss");
    label <= 3'h5;
    frames(8);
    rd_chk(STA, st(7'h2D, 3'h5));
    check(lf, 1'b1);
    check(mlf, 1'b0);
    itf <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(lf, 1'b0);
    itf <= 1'b0;
    bus(1'b1, adaptation_pkg::CTRL_OFF, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    rd_chk(STA, 32'h0000_0000);
    check(sf, 1'b1);
    check(lf, 1'b0);
    bus(1'b1, adaptation_pkg::CTRL_OFF, 32'h0000_0001);
    label <= 3'h3;
    frames(8);
    rd_chk(STA, st(7'h04, 3'h3));
    end_test("label");
    chk_on <= 1'b0;
    frames(6);
    run <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_chk(STA, st(7'h44, 3'h3));
    np0 = n_pop;
    drain <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (tug2_valid !== 1'b0 && k < 200);
    if (k >= 200)
      timeout;
    drain <= 1'b0;
    check(n_pop - np0, 32);
    bus(1'b1, STA, 32'h0000_0040);
    rd_chk(STA, st(7'h04, 3'h3));
    end_test("buffer");
    give_verdict;
  end
endmodule
`default_nettype wire
